// ==== hw/hrif_pkg.sv ====
// Constants shared by the host register interface of the data pump.
// Assumes one 20 MHz clock and an 8-bit host bus with active-low strobes.
package hrif_pkg;
  // ----------------------------------------
  // Register selects
  // ----------------------------------------
  localparam logic [2:0] SEL_DATA_LOW = 3'h0;
  localparam logic [2:0] SEL_DATA_HIGH = 3'h1;
  localparam logic [2:0] SEL_ADDR_LOW = 3'h2;
  localparam logic [2:0] SEL_PAR_DATA = 3'h3;
  localparam logic [2:0] SEL_CONTROL = 3'h4;
  localparam logic [2:0] SEL_STATUS = 3'h5;
  localparam logic [2:0] SEL_HDLC = 3'h7;
  // ----------------------------------------
  // Control and status bit positions
  // ----------------------------------------
  localparam int CTL_ADDR_HIGH = 0;
  localparam int CTL_REQUEST = 1;
  localparam int CTL_DIRECTION = 2;
  localparam int CTL_SOFT_RTS = 3;
  localparam int CTL_PAR_MODE = 4;
  localparam int CTL_RAM_IE = 5;
  localparam int CTL_RX_IE = 6;
  localparam int CTL_TX_IE = 7;
  localparam int STS_RESET = 0;
  localparam int STS_CARRIER = 1;
  localparam int STS_RETRAIN = 2;
  localparam int STS_BUSY = 4;
  localparam int STS_RAM_DONE = 5;
  localparam int STS_RX = 6;
  localparam int STS_TX = 7;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [2:0] HDLC_RESET = 3'h0;
  // ----------------------------------------
  // Configuration word and timing
  // ----------------------------------------
  localparam logic [8:0] CONFIG_ADDR = 9'h000;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_LEVEL_LSB = 8;
  localparam logic [6:0] MODE_STANDBY = 7'h00;
  localparam logic [5:0] LEVEL_MIN_ATTEN = 6'h06;
  localparam logic [5:0] LEVEL_MAX_ATTEN = 6'h2b;
  localparam logic [5:0] LEVEL_DEFAULT = 6'h0a;
  localparam int CLK_NS = 50;
  localparam int RESET_SEQ_NS = 800;
  localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] FIRMWARE_VERSION = 8'h21;  // Arbitrary value.

  typedef enum logic [2:0] {
    HRIF_IDLE = 3'b001,
    HRIF_ACCESS = 3'b010,
    HRIF_FINISH = 3'b100
  } hrif_ram_state_t;
endpackage

// ==== hw/hrif_ram.sv ====
// Word storage of the data pump RAM, held in flip-flops.
// Assumes one write port and a registered read port on the same clock.
`timescale 1ns/10ps
module hrif_ram #(
  parameter int AW = 9,
  parameter int DW = 16
) (
  // Clock
  input wire logic clk_in,
  // Access
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic [DW-1:0] rdata_out
);
  logic [DW-1:0] mem_r [2**AW];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_r[addr_in] <= wdata_in;
    end
    rdata_out <= mem_r[addr_in];
  end
endmodule

// ==== hw/hrif_top.sv ====
// Host register interface of the data pump: registers, RAM access and status.
// Assumes host strobes synchronous to clk_in and held for at least two cycles.
`timescale 1ns/10ps
module hrif_top import hrif_pkg::*; #(
  parameter int RAM_AW = 9,
  parameter logic [7:0] FW_VERSION = FIRMWARE_VERSION
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host bus
  input wire logic [7:0] hd_in,
  output logic [7:0] hd_out,
  output logic hd_oe_n_out,
  input wire logic [2:0] register_select_in,
  input wire logic hrd_n_in,
  input wire logic hwr_n_in,
  input wire logic hcs_n_in,
  output logic hirq_n_out,
  // Data pump side
  input wire logic [7:0] rx_octet_in,
  input wire logic rx_octet_valid_in,
  input wire logic tx_octet_taken_in,
  output logic [7:0] tx_octet_out,
  output logic tx_octet_valid_out,
  input wire logic carrier_detect_in,
  input wire logic retrain_in,
  input wire logic pump_busy_in,
  input wire logic [2:0] frame_event_in,
  // Serial port and configuration
  input wire logic rts_pin_in,
  input wire logic serial_rx_in,
  output logic rts_effective_out,
  output logic rxd_out,
  output logic line_signal_detect_pin_n_out,
  output logic parallel_mode_out,
  output logic [6:0] config_mode_out,
  output logic [5:0] tx_atten_out,
  output logic [2:0] bits_per_symbol_out,
  output logic shaping_on_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] bps_of(input logic [6:0] m);
    unique case (m)
      7'h01: bps_of = 3'h4;
      7'h02, 7'h03, 7'h06: bps_of = 3'h2;
      7'h04, 7'h05, 7'h07: bps_of = 3'h1;
      default: bps_of = 3'h0;
    endcase
  endfunction

  function automatic logic [5:0] clamp_level(input logic [5:0] a);
    return (a < LEVEL_MIN_ATTEN) ? LEVEL_MIN_ATTEN : (a > LEVEL_MAX_ATTEN) ? LEVEL_MAX_ATTEN : a;
  endfunction
  // ----------------------------------------
  // Host strobe decode
  // ----------------------------------------
  logic rd_act_q_r;
  logic wr_act_q_r;
  wire rd_act = !hcs_n_in && !hrd_n_in;
  wire wr_act = !hcs_n_in && !hwr_n_in;
  wire rd_start = rd_act && !rd_act_q_r;
  wire wr_start = wr_act && !wr_act_q_r;
  wire wr_data_low = wr_start && register_select_in == SEL_DATA_LOW;
  wire wr_data_high = wr_start && register_select_in == SEL_DATA_HIGH;
  wire wr_addr_low = wr_start && register_select_in == SEL_ADDR_LOW;
  wire wr_par = wr_start && register_select_in == SEL_PAR_DATA;
  wire wr_ctl = wr_start && register_select_in == SEL_CONTROL;
  wire wr_hdlc = wr_start && register_select_in == SEL_HDLC;
  wire rd_par = rd_start && register_select_in == SEL_PAR_DATA;
  wire rd_sts = rd_start && register_select_in == SEL_STATUS;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] data_low_r;
  logic [7:0] data_high_r;
  logic [7:0] addr_low_r;
  logic [7:0] par_data_r;
  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic [2:0] hdlc_r;
  logic ram_done_r;
  logic rx_flag_r;
  logic tx_flag_r;
  logic in_reset_r;
  logic [4:0] reset_cnt_r;
  logic [6:0] cfg_mode_r;
  logic [5:0] cfg_level_r;
  logic [7:0] rd_data_r;
  logic [7:0] tx_octet_r;
  logic tx_valid_r;
  hrif_ram_state_t state_r;
  hrif_ram_state_t state_nxt;

  wire standby = cfg_mode_r == MODE_STANDBY;
  wire par_mode = control_r[CTL_PAR_MODE];
  // Carrier and busy flags from the pump are forced low while held in reset or standby.
  wire carrier_sts = carrier_detect_in && !standby && !in_reset_r;
  wire busy_sts = pump_busy_in && !standby && !in_reset_r;

  wire [RAM_AW-1:0] ram_addr = RAM_AW'({control_r[CTL_ADDR_HIGH], addr_low_r});
  wire [15:0] ram_wdata = {data_high_r, data_low_r};
  wire [15:0] ram_rdata;
  wire ram_we = state_r == HRIF_ACCESS && control_r[CTL_DIRECTION];
  wire req_done = state_r == HRIF_FINISH;
  wire cfg_write = ram_we && ram_addr == RAM_AW'(CONFIG_ADDR);
  wire standby_entry = cfg_write && ram_wdata[CFG_MODE_LSB +: 7] == MODE_STANDBY;

  hrif_ram #(
    .AW(RAM_AW),
    .DW(16)
  ) u_ram (
    .clk_in(clk_in),
    .we_in(ram_we),
    .addr_in(ram_addr),
    .wdata_in(ram_wdata),
    .rdata_out(ram_rdata)
  );

  // ----------------------------------------
  // RAM request sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      HRIF_IDLE: begin
        if (control_r[CTL_REQUEST] && !in_reset_r) begin
          state_nxt = HRIF_ACCESS;
        end
      end
      HRIF_ACCESS: state_nxt = HRIF_FINISH;
      HRIF_FINISH: state_nxt = HRIF_IDLE;
      default: state_nxt = HRIF_IDLE;
    endcase
  end

  always_comb begin
    control_nxt = control_r;
    if (req_done) begin
      control_nxt[CTL_REQUEST] = 1'b0;
    end
    // A host write in the finishing cycle wins so a new request is never lost.
    if (wr_ctl) begin
      control_nxt = hd_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      control_r <= CONTROL_RESET;
      state_r <= HRIF_IDLE;
      rd_act_q_r <= 1'b0;
      wr_act_q_r <= 1'b0;
    end else begin
      control_r <= control_nxt;
      state_r <= state_nxt;
      rd_act_q_r <= rd_act;
      wr_act_q_r <= wr_act;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_low_r <= 8'h00;
      data_high_r <= 8'h00;
      addr_low_r <= 8'h00;
    end else begin
      if (req_done && !control_r[CTL_DIRECTION]) begin
        data_low_r <= ram_rdata[7:0];
        data_high_r <= ram_rdata[15:8];
      end else begin
        if (wr_data_low) begin
          data_low_r <= hd_in;
        end
        if (wr_data_high) begin
          data_high_r <= hd_in;
        end
      end
      if (wr_addr_low) begin
        addr_low_r <= hd_in;
      end
    end
  end

  // ----------------------------------------
  // Status flags; an event always beats its clear
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ram_done_r <= 1'b0;
      rx_flag_r <= 1'b0;
      tx_flag_r <= 1'b0;
      hdlc_r <= HDLC_RESET;
    end else begin
      ram_done_r <= req_done || (ram_done_r && !rd_sts);
      rx_flag_r <= (par_mode && rx_octet_valid_in) || (rx_flag_r && !rd_par);
      tx_flag_r <= (par_mode && tx_octet_taken_in) || (tx_flag_r && !wr_par);
      hdlc_r <= frame_event_in | (wr_hdlc ? hd_in[2:0] : hdlc_r);
    end
  end

  // ----------------------------------------
  // Parallel data and configuration
  // ----------------------------------------
  // version on reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      par_data_r <= FW_VERSION;
      in_reset_r <= 1'b1;
      reset_cnt_r <= 5'h00;
      cfg_mode_r <= MODE_STANDBY;
      cfg_level_r <= LEVEL_DEFAULT;
    end else begin
      if (reset_cnt_r == 5'(RESET_SEQ_CYCLES - 1)) begin
        in_reset_r <= 1'b0;
      end else begin
        reset_cnt_r <= reset_cnt_r + 5'h01;
      end
      if (standby_entry) begin
        par_data_r <= FW_VERSION;
      end else if (par_mode && rx_octet_valid_in) begin
        par_data_r <= rx_octet_in;
      end
      if (cfg_write) begin
        cfg_mode_r <= ram_wdata[CFG_MODE_LSB +: 7];
        cfg_level_r <= clamp_level(ram_wdata[CFG_LEVEL_LSB +: 6]);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_octet_r <= 8'h00;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= wr_par && par_mode;
      if (wr_par && par_mode) begin
        tx_octet_r <= hd_in;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  wire [7:0] status_val = {tx_flag_r, rx_flag_r, ram_done_r, busy_sts, 1'b0,
                           retrain_in && !in_reset_r, carrier_sts, in_reset_r};
  logic [7:0] rd_mux;
  always_comb begin
    unique case (register_select_in)
      SEL_DATA_LOW: rd_mux = data_low_r;
      SEL_DATA_HIGH: rd_mux = data_high_r;
      SEL_PAR_DATA: rd_mux = par_data_r;
      SEL_CONTROL: rd_mux = control_r;
      SEL_STATUS: rd_mux = status_val;
      SEL_HDLC: rd_mux = {5'h00, hdlc_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_mux;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Read data lags the select by a cycle, so hosts must hold a read two cycles.
  assign hd_out = rd_data_r;
  assign hd_oe_n_out = !(rd_act && rd_act_q_r);
  assign hirq_n_out = !((control_r[CTL_RAM_IE] && ram_done_r)
                      || (par_mode && control_r[CTL_RX_IE] && rx_flag_r)
                      || (par_mode && control_r[CTL_TX_IE] && tx_flag_r));
  assign rts_effective_out = control_r[CTL_SOFT_RTS] || rts_pin_in;
  assign line_signal_detect_pin_n_out = !carrier_sts;
  assign rxd_out = carrier_sts ? serial_rx_in : 1'b1;
  assign parallel_mode_out = par_mode;
  assign config_mode_out = cfg_mode_r;
  assign tx_atten_out = cfg_level_r;
  assign bits_per_symbol_out = bps_of(cfg_mode_r);
  assign shaping_on_out = bps_of(cfg_mode_r) > 3'h1;
  assign tx_octet_out = tx_octet_r;
  assign tx_octet_valid_out = tx_valid_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_req_taken;
    state_r == HRIF_IDLE && control_r[CTL_REQUEST] && !in_reset_r;
  endsequence
  sequence s_req_served;
    ##2 req_done ##1 ram_done_r;
  endsequence
  property p_req_flow;
    @(posedge clk_in) disable iff (!rst_n_in) s_req_taken |-> s_req_served;
  endproperty
  a_req_flow: assert property (p_req_flow) else $error("RAM request not served");
  property p_req_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      req_done && !wr_ctl |=> !control_r[CTL_REQUEST];
  endproperty
  a_req_clear: assert property (p_req_clear) else $error("request bit kept");
  property p_read_load;
    @(posedge clk_in) disable iff (!rst_n_in)
      req_done && !control_r[CTL_DIRECTION] |=> {data_high_r, data_low_r} == $past(ram_rdata);
  endproperty
  a_read_load: assert property (p_read_load) else $error("read word not loaded");
  property p_rts;
    @(posedge clk_in) disable iff (!rst_n_in)
      rts_effective_out == (control_r[CTL_SOFT_RTS] || rts_pin_in);
  endproperty
  a_rts: assert property (p_rts) else $error("request-to-send wrong");
  property p_clamp;
    @(posedge clk_in) disable iff (!rst_n_in) line_signal_detect_pin_n_out |-> rxd_out;
  endproperty
  a_clamp: assert property (p_clamp) else $error("receive data not clamped");
  property p_rx_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
      par_mode && rx_octet_valid_in && !standby_entry
      |=> rx_flag_r && par_data_r == $past(rx_octet_in);
  endproperty
  a_rx_flag: assert property (p_rx_flag) else $error("receive octet lost");
  property p_rx_clear;
    @(posedge clk_in) disable iff (!rst_n_in) rd_par && !rx_octet_valid_in |=> !rx_flag_r;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("receive flag kept");
  property p_version;
    @(posedge clk_in) disable iff (!rst_n_in) standby_entry |=> par_data_r == FW_VERSION;
  endproperty
  a_version: assert property (p_version) else $error("version not placed");
  property p_level;
    @(posedge clk_in) disable iff (!rst_n_in)
      tx_atten_out >= LEVEL_MIN_ATTEN && tx_atten_out <= LEVEL_MAX_ATTEN;
  endproperty
  a_level: assert property (p_level) else $error("level out of range");
  property p_ram_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
      control_r[CTL_RAM_IE] && req_done && !wr_ctl |=> !hirq_n_out;
  endproperty
  a_ram_irq: assert property (p_ram_irq) else $error("no RAM interrupt");
endmodule

// ==== sim/hrif_pump_model.sv ====
// Model of the data pump core behind the host register interface.
// Assumes it shares clk_in with the interface and is steered by bench task calls.
`timescale 1ns/10ps
module hrif_pump_model (
  // Clock
  input wire logic clk_in,
  // Octets from the interface
  input wire logic [7:0] tx_octet_in,
  input wire logic tx_octet_valid_in,
  // Octets and line state towards the interface
  output logic [7:0] rx_octet_out,
  output logic rx_octet_valid_out,
  output logic tx_octet_taken_out,
  output logic carrier_detect_out,
  output logic retrain_out,
  output logic pump_busy_out,
  output logic [2:0] frame_event_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] last_tx = 8'h00;
  int take_delay = 2;
  initial begin
    rx_octet_out = 8'h00;
    rx_octet_valid_out = 1'b0;
    tx_octet_taken_out = 1'b0;
    carrier_detect_out = 1'b0;
    retrain_out = 1'b0;
    pump_busy_out = 1'b0;
    frame_event_out = 3'h0;
  end
  // ----------------------------------------
  // Transmit side: takes an octet some cycles after it is offered
  // ----------------------------------------
  always begin
    @(posedge clk_in);
    if (tx_octet_valid_in) begin
      last_tx = tx_octet_in;
      repeat (take_delay) @(posedge clk_in);
      tx_octet_taken_out <= 1'b1;
      @(posedge clk_in);
      tx_octet_taken_out <= 1'b0;
    end
  end
  // ----------------------------------------
  // Bench controls
  // ----------------------------------------
  // The octet bus is inverted once released, so a stale value cannot pass for new data.
  task automatic send_octet(input logic [7:0] d);
    @(posedge clk_in);
    rx_octet_out <= d;
    rx_octet_valid_out <= 1'b1;
    @(posedge clk_in);
    rx_octet_valid_out <= 1'b0;
    rx_octet_out <= ~d;
  endtask
  task automatic pulse_events(input logic [2:0] e);
    @(posedge clk_in);
    frame_event_out <= e;
    @(posedge clk_in);
    frame_event_out <= 3'h0;
  endtask
  task automatic set_line(input logic c, input logic r, input logic b);
    @(posedge clk_in);
    carrier_detect_out <= c;
    retrain_out <= r;
    pump_busy_out <= b;
  endtask
endmodule

// ==== sim/hrif_test.sv ====
// Self-checking bench of the host register interface.
// Assumes the interface and the pump model; the bench plays the host processor.
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module hrif_test import hrif_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] hd_in = 8'h00;
  logic [2:0] rsel = 3'h0;
  logic hrd_n = 1'b1, hwr_n = 1'b1, hcs_n = 1'b1, rts_pin = 1'b0, serial_rx = 1'b1;
  logic [7:0] hd_out, tx_octet, rx_octet, v, s;
  logic hd_oe_n, hirq_n, tx_valid, rts_eff, rxd, lsd_n, par_mode, shaping;
  logic rx_valid, taken, cd, rt, busy;
  logic [6:0] cfg_mode;
  logic [5:0] atten, a6;
  logic [2:0] bps, fe;
  logic [15:0] r;
  int miscompares = 0, n_compared = 0, cycles = 0, m;
  always #25 clk_in = ~clk_in;
  hrif_top hrif_top_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .hd_in(hd_in), .hd_out(hd_out),
    .hd_oe_n_out(hd_oe_n), .register_select_in(rsel), .hrd_n_in(hrd_n), .hwr_n_in(hwr_n),
    .hcs_n_in(hcs_n), .hirq_n_out(hirq_n), .rx_octet_in(rx_octet), .rx_octet_valid_in(rx_valid),
    .tx_octet_taken_in(taken), .tx_octet_out(tx_octet), .tx_octet_valid_out(tx_valid),
    .carrier_detect_in(cd), .retrain_in(rt), .pump_busy_in(busy), .frame_event_in(fe),
    .rts_pin_in(rts_pin), .serial_rx_in(serial_rx), .rts_effective_out(rts_eff),
    .rxd_out(rxd), .line_signal_detect_pin_n_out(lsd_n), .parallel_mode_out(par_mode),
    .config_mode_out(cfg_mode), .tx_atten_out(atten), .bits_per_symbol_out(bps),
    .shaping_on_out(shaping));
  hrif_pump_model hrif_pump_model_i (.clk_in(clk_in), .tx_octet_in(tx_octet),
    .tx_octet_valid_in(tx_valid), .rx_octet_out(rx_octet), .rx_octet_valid_out(rx_valid),
    .tx_octet_taken_out(taken), .carrier_detect_out(cd), .retrain_out(rt),
    .pump_busy_out(busy), .frame_event_out(fe));
  // ----------------------------------------
  // Host bus tasks
  // ----------------------------------------
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    rsel <= a;
    hd_in <= d;
    hcs_n <= 1'b0;
    hwr_n <= 1'b0;
    repeat (2) @(posedge clk_in);
    hcs_n <= 1'b1;
    hwr_n <= 1'b1;
    @(posedge clk_in);
  endtask
  // Data is taken right after the first strobed edge, before read side effects show.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rsel <= a;
    hcs_n <= 1'b0;
    hrd_n <= 1'b0;
    @(posedge clk_in);
    #1 d = hd_out;
    `CHK(hd_oe_n, 1'b0)
    @(posedge clk_in);
    hcs_n <= 1'b1;
    hrd_n <= 1'b1;
    @(posedge clk_in);
  endtask
  task automatic ram(input logic [8:0] a, input logic w, input logic [15:0] wd,
                     input logic [7:0] extra, output logic [15:0] q);
    logic [7:0] c;
    int i;
    if (w) begin
      wr(SEL_DATA_LOW, wd[7:0]);
      wr(SEL_DATA_HIGH, wd[15:8]);
    end
    wr(SEL_ADDR_LOW, a[7:0]);
    wr(SEL_CONTROL, extra | {5'h0, w, 1'b0, a[8]});
    wr(SEL_CONTROL, extra | {5'h0, w, 1'b1, a[8]});
    c = 8'h02;
    for (i = 0; i < 20 && c[1]; i++) rd(SEL_CONTROL, c);
    `CHK(c[1], 1'b0)
    rd(SEL_DATA_LOW, q[7:0]);
    rd(SEL_DATA_HIGH, q[15:8]);
  endtask
  function automatic logic [2:0] bps_of(input int md);
    case (md)
      1: return 3'd4;
      2, 3, 6: return 3'd2;
      4, 5, 7: return 3'd1;
      default: return 3'd0;
    endcase
  endfunction
  function automatic logic [5:0] clamp(input logic [5:0] x);
    return (x < LEVEL_MIN_ATTEN) ? LEVEL_MIN_ATTEN : (x > LEVEL_MAX_ATTEN) ? LEVEL_MAX_ATTEN : x;
  endfunction
  task automatic done(input string n);
    $display("test %s finished, %0d mismatches so far", n, miscompares);
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Hang guard, far above the few hundred cycles the tests need
  // ----------------------------------------
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(SEL_CONTROL, v); `CHK(v, CONTROL_RESET)
    rd(SEL_PAR_DATA, v); `CHK(v, FIRMWARE_VERSION)
    `CHK(atten, LEVEL_DEFAULT)
    `CHK(rxd, 1'b1)
    repeat (RESET_SEQ_CYCLES) @(posedge clk_in);
    done("reset");
    ram(9'h1a5, 1'b1, 16'hbeef, 8'h00, r);
    ram(9'h0a5, 1'b1, 16'h1234, 8'h00, r);
    ram(9'h1a5, 1'b0, 16'h0000, 8'h00, r); `CHK(r, 16'hbeef)
    ram(9'h0a5, 1'b0, 16'h0000, 8'h20, r); `CHK(r, 16'h1234)
    `CHK(hirq_n, 1'b0)
    rd(SEL_STATUS, v); `CHK(v[5], 1'b1)
    rd(SEL_STATUS, v); `CHK(v[5], 1'b0)
    `CHK(hirq_n, 1'b1)
    done("ram");
    for (m = 1; m < 8; m++) begin
      a6 = (m == 1) ? 6'h3f : (m == 2) ? 6'h02 : 6'(6 + m * 5);
      ram(9'h000, 1'b1, {2'h0, a6, 1'b0, m[6:0]}, 8'h00, r);
      `CHK(cfg_mode, m[6:0])
      `CHK(bps, bps_of(m))
      `CHK(shaping, bps_of(m) > 3'd1)
      `CHK(atten, clamp(a6))
    end
    done("config");
    for (m = 0; m < 4; m++) begin
      wr(SEL_CONTROL, {4'h0, m[1], 3'h0});
      rts_pin <= m[0];
      @(posedge clk_in);
      #1 `CHK(rts_eff, m[1] | m[0])
    end
    hrif_pump_model_i.set_line(1'b1, 1'b1, 1'b1);
    serial_rx <= 1'b0;
    rd(SEL_STATUS, v); `CHK(v & 8'h17, 8'h16)
    `CHK(lsd_n, 1'b0)
    `CHK(rxd, 1'b0)
    hrif_pump_model_i.set_line(1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk_in);
    #1 `CHK(rxd, 1'b1)
    `CHK(lsd_n, 1'b1)
    done("line");
    wr(SEL_CONTROL, 8'h50); `CHK(par_mode, 1'b1)
    hrif_pump_model_i.send_octet(8'h3c);
    @(posedge clk_in);
    #1 `CHK(hirq_n, 1'b0)
    rd(SEL_STATUS, v); `CHK(v[6], 1'b1)
    rd(SEL_PAR_DATA, v); `CHK(v, 8'h3c)
    rd(SEL_STATUS, v); `CHK(v[6], 1'b0)
    wr(SEL_PAR_DATA, 8'hc5);
    repeat (4) @(posedge clk_in);
    `CHK(hrif_pump_model_i.last_tx, 8'hc5)
    rd(SEL_STATUS, v); `CHK(v[7], 1'b1)
    wr(SEL_CONTROL, 8'h90); `CHK(hirq_n, 1'b0)
    wr(SEL_CONTROL, 8'h00);
    hrif_pump_model_i.send_octet(8'h77);
    rd(SEL_STATUS, v); `CHK(v[6], 1'b0)
    ram(9'h000, 1'b1, 16'h0a00, 8'h00, r);
    rd(SEL_PAR_DATA, v); `CHK(v, FIRMWARE_VERSION)
    done("parallel");
    hrif_pump_model_i.pulse_events(3'b101);
    rd(SEL_HDLC, v); `CHK(v, 8'h05)
    wr(SEL_HDLC, 8'h00);
    rd(SEL_HDLC, v); `CHK(v, 8'h00)
    wr(3'h6, 8'hff);
    rd(3'h6, v); `CHK(v, 8'h00)
    // The done flag clears on a status read, so it is masked out here.
    rd(SEL_STATUS, s);
    wr(SEL_STATUS, 8'hff);
    rd(SEL_STATUS, v); `CHK(v & 8'hdf, s & 8'hdf)
    wr(SEL_CONTROL, 8'h5d);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(SEL_CONTROL, v); `CHK(v, CONTROL_RESET)
    done("refused and reset");
    end_of_test();
  end
endmodule
